// ---- rtl/srw_supervisor.sv ----
/*
  Supervisor reset watchdog: drives an active-low reset and its inverse from
  supply good, a debounced manual reset and a watchdog timer.
  Assumes all pin inputs are asynchronous to clk; supply good is already digital
  and the floating-input detector is a separate digital indication.
*/
// How it works
// [R1] Hold reset for hold time after supply good
// [R2] Supply loss asserts reset at once
// [R3] Every reset lasts at least full hold time
// [R4] Supply loss restarts hold timer from zero
// [R5] Active-high output is inverse of low
// [R6] Low manual input asserts reset
// [R7] Reset held while manual low, plus hold
// [R8] Open manual input reads as inactive high
// [R9] Switch bounce filtered, one clean reset
// [R10] No kick within timeout asserts reset
// [R11] Kick or reset clears watchdog timer
// [R12] Watchdog held at zero during reset
// [R13] Watchdog counts right after reset release
// [R14] Floating kick input never causes reset
// [R15] Internal driver low 7/8, high 1/8
// [R16] Internal driver clears timer every 1.4s
// [R17] Processor keeps kick low, pulses early
// [R18] Processor toggles at separate program points
// [R19] Both kick edges count as toggle
// [R20] Inputs synchronised; durations are clock counts
// [R21] Floating indication selects internal self driver
`timescale 1ns/1ns
module srw_supervisor
  import srw_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES     = HOLD_CYC,
  parameter int unsigned WD_CYCLES       = WD_CYC,
  parameter int unsigned SELF_CYCLES     = SELF_KICK_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic supply_good,
  input  wire logic manual_reset_in_n,
  input  wire logic watchdog_kick_in,
  input  wire logic kick_floating,
  output logic      reset_out_n,
  output logic      reset_out,
  output logic      watchdog_fired
);

  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] WD_LAST   = CNT_W'(WD_CYCLES - 1);
  localparam logic [CNT_W-1:0] SELF_LAST = CNT_W'(SELF_CYCLES - 1);
  localparam logic [CNT_W-1:0] SELF_HIGH = CNT_W'((SELF_CYCLES / SELF_DEN) * SELF_LOW_NUM);
  localparam logic [CNT_W-1:0] DEB_LAST  = CNT_W'(DEBOUNCE_CYCLES - 1);

  // Saturating increment used by the debounce, watchdog and hold timers
  function automatic logic [CNT_W-1:0] srw_inc(input logic [CNT_W-1:0] v,
                                               input logic [CNT_W-1:0] last);
    srw_inc = (v >= last) ? last : v + CNT_W'(1);
  endfunction : srw_inc

  // Three-stage synchronisers: supply and kick reset low, manual and floating reset high
  logic [2:0] sup_q;
  logic [2:0] mr_q;
  logic [2:0] kick_q;
  logic [2:0] flt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sup_q  <= 3'h0;
      mr_q   <= 3'h7;            // R8
      kick_q <= 3'h0;
      flt_q  <= 3'h7;
    end else begin
      sup_q  <= {sup_q[1:0], supply_good};        // R20
      mr_q   <= {mr_q[1:0], manual_reset_in_n};   // R20
      kick_q <= {kick_q[1:0], watchdog_kick_in};  // R20
      flt_q  <= {flt_q[1:0], kick_floating};      // R20
    end
  end

  // Settled levels: change only when stages two and three agree
  logic sup_s_q;
  logic mr_s_q;
  logic kick_s_q;
  logic flt_s_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sup_s_q  <= 1'b0;
      mr_s_q   <= 1'b1;
      kick_s_q <= 1'b0;
      flt_s_q  <= 1'b1;
    end else begin
      if (sup_q[1] == sup_q[2]) sup_s_q <= sup_q[2];
      if (mr_q[1] == mr_q[2]) mr_s_q <= mr_q[2];
      if (kick_q[1] == kick_q[2]) kick_s_q <= kick_q[2];
      if (flt_q[1] == flt_q[2]) flt_s_q <= flt_q[2];
    end
  end

  // Manual reset debounce: press takes effect at once, release needs quiet time
  logic [CNT_W-1:0] deb_q;
  logic             mr_act_q;
  wire              deb_done = (deb_q >= DEB_LAST);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deb_q    <= '0;
      mr_act_q <= 1'b0;
    end else if (!mr_s_q) begin
      deb_q    <= '0;            // R9
      mr_act_q <= 1'b1;          // R6
    end else begin
      deb_q    <= srw_inc(deb_q, DEB_LAST);
      if (deb_done) mr_act_q <= 1'b0;  // R9
    end
  end

  // Internal self-toggling driver on the kick input
  logic [CNT_W-1:0] self_q;
  wire              self_level = (self_q >= SELF_HIGH);  // R15
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      self_q <= '0;
    end else if (self_q >= SELF_LAST) begin
      self_q <= '0;              // R16
    end else begin
      self_q <= self_q + CNT_W'(1);
    end
  end

  // Kick source select and edge detection on either edge
  wire  kick_level = flt_s_q ? self_level : kick_s_q;  // R21 R14
  logic kick_prev_q;
  wire  kick_edge  = kick_level ^ kick_prev_q;          // R19 R11
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) kick_prev_q <= 1'b0;
    else        kick_prev_q <= kick_level;
  end

  // Reset state machine and timers
  srw_state_t       state_q;
  srw_state_t       state_d;
  logic [CNT_W-1:0] hold_q;
  logic [CNT_W-1:0] hold_d;
  logic [CNT_W-1:0] wd_q;
  logic [CNT_W-1:0] wd_d;
  srw_cause_t       cause;
  wire              wd_expire = (state_q == SRW_RUN) && (wd_q >= WD_LAST);  // R10
  wire              any_cause = cause.supply | cause.manual | cause.watchdog;

  assign cause.supply   = !sup_s_q;    // R2
  assign cause.manual   = mr_act_q;    // R6 R7
  assign cause.watchdog = wd_expire;   // R10

  always_comb begin
    state_d = state_q;
    hold_d  = hold_q;
    wd_d    = wd_q;
    case (state_q)
      SRW_RUN: begin
        if (any_cause) begin
          state_d = SRW_HOLD;        // R2 R6 R10
          hold_d  = '0;              // R3
          wd_d    = '0;              // R11
        end else if (kick_edge) begin
          wd_d    = '0;              // R11
        end else begin
          wd_d    = srw_inc(wd_q, WD_LAST);  // R13
        end
      end
      SRW_HOLD: begin
        wd_d = '0;                   // R12
        if (cause.supply || cause.manual) begin
          hold_d = '0;               // R4 R7
        end else if (hold_q >= HOLD_LAST) begin
          state_d = SRW_RUN;         // R1 R3
        end else begin
          hold_d  = srw_inc(hold_q, HOLD_LAST);
        end
      end
      default: begin
        state_d = SRW_HOLD;
        hold_d  = '0;
        wd_d    = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SRW_HOLD;
      hold_q  <= '0;
      wd_q    <= '0;
    end else begin
      state_q <= state_d;
      hold_q  <= hold_d;
      wd_q    <= wd_d;
    end
  end

  // Registered outputs, kept exact complements
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_out_n    <= 1'b0;
      reset_out      <= 1'b1;
      watchdog_fired <= 1'b0;
    end else begin
      reset_out_n    <= (state_d == SRW_RUN);   // R5
      reset_out      <= (state_d != SRW_RUN);   // R5
      watchdog_fired <= wd_expire;
    end
  end

endmodule : srw_supervisor

// ---- shared/srw_pkg.sv ----
/*
  Package for the supervisor reset watchdog: timing constants, the derived
  cycle counts and the packed carriers that group the block's input pins and reset causes.
  Assumes a single 50 MHz clock.
*/
package srw_pkg;

  // Timebase
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CLK_NS          = 20;

  // Documented times in their own units
  localparam int unsigned HOLD_MS         = 200;   // reset_hold_time
  localparam int unsigned WD_TIMEOUT_MS   = 1600;  // watchdog_timeout
  localparam int unsigned SELF_KICK_MS    = 1400;  // internal driver service period
  localparam int unsigned KICK_MIN_NS     = 50;    // shortest recognised toggle
  localparam int unsigned DEBOUNCE_US     = 1000;  // switch bounce settling window

  // Cycle counts: least times round up, longest times round down
  localparam int unsigned HOLD_CYC        = (HOLD_MS * (CLK_HZ / 1000));
  localparam int unsigned WD_CYC          = (WD_TIMEOUT_MS * (CLK_HZ / 1000));
  localparam int unsigned SELF_KICK_CYC   = (SELF_KICK_MS * (CLK_HZ / 1000));
  localparam int unsigned KICK_MIN_CYC    = (KICK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DEBOUNCE_CYC    = (DEBOUNCE_US * (CLK_HZ / 1_000_000));

  // Internal driver phases: low for 7/8 of its period, high for the last 1/8
  localparam int unsigned SELF_LOW_NUM    = 7;
  localparam int unsigned SELF_DEN        = 8;

  localparam int unsigned CNT_W           = 32;

  // Raw pins entering the block
  typedef struct packed {
    logic supply_good;
    logic manual_reset_in_n;
    logic watchdog_kick_in;
    logic kick_floating;
  } srw_pins_t;

  // Why reset is being held
  typedef struct packed {
    logic supply;
    logic manual;
    logic watchdog;
  } srw_cause_t;

  // Block state
  typedef enum logic [1:0] {
    SRW_HOLD,
    SRW_RUN
  } srw_state_t;

endpackage : srw_pkg

// ---- bench/srw_chk.sv ----
/* Port checker for the supervisor reset watchdog.
   Assumes it is bound to every srw_supervisor instance. */
`timescale 1ns/1ns
module srw_chk
  import srw_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYC,
  parameter int unsigned WD_CYCLES   = WD_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_good,
  input wire logic manual_reset_in_n,
  input wire logic watchdog_kick_in,
  input wire logic kick_floating,
  input wire logic reset_out_n,
  input wire logic reset_out,
  input wire logic watchdog_fired
);
  logic [CNT_W-1:0] low_q, quiet_q;
  // Reset length, and released time with no kick edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= '0;
      quiet_q <= '0;
    end else begin
      low_q <= reset_out_n ? '0 : low_q + 1'b1;
      quiet_q <= (!reset_out_n || kick_floating || $changed(watchdog_kick_in)) ? '0 : quiet_q + 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_press; $fell(manual_reset_in_n) ##1 !manual_reset_in_n [*3]; endsequence
  sequence s_held; ##[0:3] !reset_out_n ##1 !reset_out_n [*8]; endsequence
  property p_inv; reset_out == !reset_out_n; endproperty
  a_inv: assert property (p_inv) else $error("outputs not inverse");
  property p_brown; $fell(supply_good) ##1 !supply_good [*3] |-> ##[0:6] !reset_out_n; endproperty
  a_brown: assert property (p_brown) else $error("no reset on supply loss");
  property p_press; s_press |-> ##[0:8] !reset_out_n; endproperty
  a_press: assert property (p_press) else $error("no reset on press");
  property p_hold; $rose(reset_out_n) |-> low_q >= HOLD_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("reset too short");
  property p_fire; watchdog_fired |-> s_held; endproperty
  a_fire: assert property (p_fire) else $error("expiry without reset");
  property p_wd_min; watchdog_fired |-> quiet_q + 4 >= WD_CYCLES; endproperty
  a_wd_min: assert property (p_wd_min) else $error("watchdog early");
  property p_wd_max; quiet_q <= WD_CYCLES + 8; endproperty
  a_wd_max: assert property (p_wd_max) else $error("watchdog late");
  property p_float; kick_floating && $past(kick_floating, 4) |-> !watchdog_fired; endproperty
  a_float: assert property (p_float) else $error("open kick pin fired");
endmodule : srw_chk

bind srw_supervisor srw_chk #(.HOLD_CYCLES(HOLD_CYCLES), .WD_CYCLES(WD_CYCLES)) u_chk (.clk, .rst_n,
  .supply_good, .manual_reset_in_n, .watchdog_kick_in, .kick_floating, .reset_out_n, .reset_out, .watchdog_fired);

// ---- bench/srw_cpu_model.sv ----
/* Processor model: services the kick pin while reset is released.
   Assumes the supervisor's clock. */
`timescale 1ns/1ns
module srw_cpu_model
  import srw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_out_n,
  input  wire logic        run,
  input  wire logic        split,
  input  wire logic [15:0] gap,
  output logic             kick
);
  logic [15:0] cnt_q;
  // Short high pulse, or level flips at separate points
  always_ff @(posedge clk) begin
    if (!reset_out_n) begin
      cnt_q <= '0;
      kick <= 1'b0;
    end else if (run) begin
      cnt_q <= (cnt_q == gap) ? '0 : cnt_q + 1'b1;
      if (cnt_q == gap) kick <= split ? ~kick : 1'b1;
      else if (!split && cnt_q == 16'h0003) kick <= 1'b0;
    end
  end
endmodule : srw_cpu_model

// ---- bench/testbench.sv ----
/* Self-checking bench at shortened counts.
   Assumes the bound checker and the processor model. */
`timescale 1ns/1ns
module testbench;
  import srw_pkg::*;
  localparam int H = 40;
  localparam int W = 200;
  logic clk, rst_n, supply_good, manual_reset_in_n, kick_floating, run, split, kick_d;
  logic watchdog_kick_in, reset_out_n, reset_out, watchdog_fired;
  logic [15:0] gap;
  int fails, checks_done, cyc, seed, c, n, fired_n, quiet, rises;
  srw_supervisor #(.HOLD_CYCLES(H), .WD_CYCLES(W), .SELF_CYCLES(160), .DEBOUNCE_CYCLES(8)) dut (.clk, .rst_n,
    .supply_good, .manual_reset_in_n, .watchdog_kick_in, .kick_floating, .reset_out_n, .reset_out, .watchdog_fired);
  srw_cpu_model cpu (.clk, .reset_out_n, .run, .split, .gap, .kick(watchdog_kick_in));
  // Release delay after the last cause clears
  function automatic int rel(input int extra);
    return H + extra;
  endfunction : rel
  task automatic chk(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      fails++;
      $display("BAD %s exp %0d..%0d got %0d", what, lo, hi, got);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask : step
  task automatic rel_wait();
    for (c = 0; reset_out_n !== 1'b1 && c < 4000; c++) @(negedge clk);
  endtask : rel_wait
  // Supply dip, kick pin open or driven, then wait for release
  task automatic dip(input int k, input logic fl);
    @(posedge clk) supply_good <= 1'b0;
    kick_floating <= fl;
    step(k);
    supply_good <= 1'b1;
    rel_wait();
  endtask : dip
  task automatic close_out();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge reset_out_n) rises++;
  // Fired pulses, released cycles since a kick edge, cycle ceiling
  always @(posedge clk) begin
    fired_n += (watchdog_fired === 1'b1);
    quiet = (watchdog_kick_in !== kick_d || reset_out_n !== 1'b1) ? 0 : quiet + 1;
    kick_d = watchdog_kick_in;
    if (++cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    {rst_n, supply_good, run, split, kick_d, manual_reset_in_n, kick_floating} = 7'h03;
    {fails, checks_done, cyc, fired_n, quiet, rises} = '0;
    gap = 16'h0040;
    seed = 32'hc0fa50da;
    step(16);
    rst_n <= 1'b1;
    step(9);
    chk("held at power-up", 0, 0, reset_out_n !== 1'b0);
    dip(1, 1'b1);
    chk("power-up hold", rel(0), rel(12), c);
    // Brownout, then a second dip inside the hold
    repeat (3) begin
      @(posedge clk) supply_good <= 1'b0;
      step(4 + {$random(seed)} % 8);
      supply_good <= 1'b1;
      step(5 + {$random(seed)} % 30);
      chk("brownout", 0, 0, reset_out_n !== 1'b0);
      dip(4, 1'b1);
      chk("restarted hold", rel(0), rel(12), c);
    end
    // Bouncing press and release of the manual input
    repeat (2) begin
      n = rises;
      repeat (5) @(posedge clk) manual_reset_in_n <= ~manual_reset_in_n;
      step(20 + {$random(seed)} % 40);
      chk("manual held", 0, 0, reset_out_n !== 1'b0);
      repeat (5) begin
        manual_reset_in_n <= ~manual_reset_in_n;
        step(1 + {$random(seed)} % 4);
      end
      rel_wait();
      chk("manual hold", rel(4), rel(22), c);
      chk("one release", n + 1, n + 1, rises);
    end
    // Kicked watchdog in pulse and split styles
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      split <= s[0];
      gap <= 16'(20 + {$random(seed)} % 150);
      run <= 1'b1;
      dip(6, 1'b0);
      n = fired_n;
      step(3 * W);
      chk("serviced", n, n, fired_n);
    end
    // Silent processor: expiry, hold, restart at release
    run <= 1'b0;
    repeat (2) begin
      for (c = 0; watchdog_fired !== 1'b1 && c < 1000; c++) @(negedge clk);
      chk("expiry", W - 2, W + 10, quiet);
      rel_wait();
      chk("watchdog hold", rel(-8), rel(8), c);
    end
    dip(6, 1'b1);
    n = fired_n;
    step(4 * W);
    chk("open kick pin", n, n, fired_n);
    close_out();
  end
endmodule : testbench
